/* common/pmicef_pkg.sv */
// Functional notes
// - reset-event flag bit 0 sets on analog undervoltage or soft reset request.
// - reset event disables converters, restores register defaults, reruns start-up.
// - sticky flags clear on a written one or a reset event; written zero keeps them.
// - step-down short flag sets when output falls below 0.35 V while running.
// - step-down short flag sets when output misses 0.35 V within 1 ms.
// - step-up short flag sets when output falls to input level or 2.5 V.
// - step-up short flag sets when output misses 2.5 V within 1 ms.
// - current-limit flags latch: step-down bits 0 and 4, step-up bit 0.
// - power-good event flags latch: step-down bits 2 and 6, step-up bit 2.
// - monitor flags: second monitor bit 4, first bit 2, analog supply bit 0.
// - live bit 3 reads 1 while external clock frequency is invalid.
// - live bit 2 reads 1 while die is above thermal shutdown level.
// - live bit 1 reads 1 while die is above thermal warning level.
// - live bit 0 reads 1 while input voltage is above overvoltage level.
// - all event and status registers reset to zero.
// - step-down summary bit clears itself once its flag register is zero.
// - soft reset request restores defaults, reloads one-time memory, self-clears.
`default_nettype none
package pmicef_pkg;

	localparam int CLK_MHZ = 50;
	localparam int STARTUP_TIMEOUT_US = 1000;
	localparam int STARTUP_CYCLES = STARTUP_TIMEOUT_US * CLK_MHZ;
	localparam logic [4:0] OFF_CYCLES = 5'h10;

	localparam logic [7:0] IDX_RESET_FLAGS = 8'h21;
	localparam logic [7:0] IDX_STEPDOWN_FLAGS = 8'h22;
	localparam logic [7:0] IDX_STEPUP_FLAGS = 8'h23;
	localparam logic [7:0] IDX_MONITOR_FLAGS = 8'h24;
	localparam logic [7:0] IDX_TOP_LIVE = 8'h25;
	localparam logic [7:0] IDX_CONTROL = 8'h30;
	localparam logic [7:0] IDX_ENABLE = 8'h31;
	localparam logic [7:0] IDX_MASK = 8'h32;
	localparam logic [7:0] IDX_SUMMARY = 8'h33;

	localparam int R_RST = 0;
	localparam int R_SD = 1;
	localparam int R_SU = 2;
	localparam int R_MON = 3;

	localparam int B_RST_EVT = 0;
	localparam int B_SDA_LIM = 0;
	localparam int B_SDA_SHORT = 1;
	localparam int B_SDA_PG = 2;
	localparam int B_SDB_LIM = 4;
	localparam int B_SDB_SHORT = 5;
	localparam int B_SDB_PG = 6;
	localparam int B_SU_LIM = 0;
	localparam int B_SU_SHORT = 1;
	localparam int B_SU_PG = 2;
	localparam int B_MON_ANALOG = 0;
	localparam int B_MON_FIRST = 2;
	localparam int B_MON_SECOND = 4;
	localparam int B_SOFT_RESET = 0;

	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [7:0] LIVE_RESET = 8'h00;
	localparam logic [2:0] ENABLE_RESET = 3'h7;
	localparam logic [31:0] MASK_RESET = 32'h0;
	// reserved bits that software may write and read back
	localparam logic [3:0][7:0] FLAG_RW = {8'hEA, 8'hF8, 8'h88, 8'hFE};

	typedef enum logic [2:0] {
		ST_OFF = 3'h1,
		ST_START = 3'h2,
		ST_RUN = 3'h4
	} pmicef_state_t;

	typedef struct packed {
		logic clk_invalid;
		logic thermal_shutdown_state;
		logic thermal_warning_state;
		logic input_overvoltage_state;
	} pmicef_live_t;

	typedef struct packed {
		logic analog_supply_uv;
		logic [1:0] stepdown_above;
		logic stepup_above;
		logic [2:0] conv_limit;
		logic [2:0] conv_pgood;
		logic [2:0] monitor_pgood;
		pmicef_live_t live;
	} pmicef_pins_t;

endpackage
`default_nettype wire

/* logic/pmicef_event_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module pmicef_event_flags #(
	parameter int STARTUP_CYCLES = pmicef_pkg::STARTUP_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pmicef_pkg::pmicef_pins_t pins,
	output logic [2:0] conv_enable,
	output logic otp_reload,
	output logic irq
);
	pmicef_pkg::pmicef_pins_t pins_m;
	pmicef_pkg::pmicef_pins_t pins_s;
	logic uv_d;
	logic [2:0] limit_d;
	logic [2:0] pgood_d;
	logic [2:0] mon_d;
	logic uv_rise;
	logic [2:0] limit_rise;
	logic [2:0] pgood_chg;
	logic [2:0] mon_chg;
	logic [2:0] short_evt;
	logic [2:0] conv_above;
	logic [3:0][7:0] flags;
	logic [3:0][7:0] next_flags;
	logic [3:0][7:0] set_v;
	logic [3:0] wr_sel;
	logic [3:0] summary;
	logic [2:0] enable_reg;
	logic [31:0] mask_reg;
	logic soft_req;
	logic restart_evt;
	logic [7:0] idx;
	logic hit;
	logic wr_en;
	logic [31:0] rd_data;
	logic [4:0] off_cnt;
	pmicef_pkg::pmicef_state_t state;

	// pins come from the analog side, two stages before any use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_m <= '0;
			pins_s <= '0;
		end else begin
			pins_m <= pins;
			pins_s <= pins_m;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uv_d <= 1'b0;
			limit_d <= 3'h0;
			pgood_d <= 3'h0;
			mon_d <= 3'h0;
		end else begin
			uv_d <= pins_s.analog_supply_uv;
			limit_d <= pins_s.conv_limit;
			pgood_d <= pins_s.conv_pgood;
			mon_d <= pins_s.monitor_pgood;
		end
	end

	assign uv_rise = pins_s.analog_supply_uv && !uv_d;
	assign limit_rise = pins_s.conv_limit & ~limit_d;
	// a power-good event is any change of the raw level
	assign pgood_chg = pins_s.conv_pgood ^ pgood_d;
	assign mon_chg = pins_s.monitor_pgood ^ mon_d;
	assign restart_evt = uv_rise || soft_req;

	assign conv_above = {pins_s.stepup_above, pins_s.stepdown_above};

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_timer
			// step-up comparator also trips at input level
			pmicef_start_timer #(
				.LIMIT(STARTUP_CYCLES)
			) u_timer (
				.pclk(pclk),
				.presetn(presetn),
				.en(conv_enable[g]),
				.above(conv_above[g]),
				.running(),
				.short_evt(short_evt[g])
			);
		end
	endgenerate

	// apb decode
	assign idx = paddr[9:2];
	assign wr_en = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;

	always_comb begin
		hit = 1'b0;
		if (paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0) begin
			hit = (idx >= pmicef_pkg::IDX_RESET_FLAGS && idx <= pmicef_pkg::IDX_TOP_LIVE)
				|| (idx >= pmicef_pkg::IDX_CONTROL && idx <= pmicef_pkg::IDX_SUMMARY);
		end
		for (int k = 0; k < 4; k++) begin
			wr_sel[k] = wr_en && hit && (idx == pmicef_pkg::IDX_RESET_FLAGS + 8'(k));
		end
	end

	// event sources, each to its flag position
	always_comb begin
		set_v = '0;
		set_v[pmicef_pkg::R_RST][pmicef_pkg::B_RST_EVT] = restart_evt;
		set_v[pmicef_pkg::R_SD][pmicef_pkg::B_SDA_LIM] = limit_rise[0];
		set_v[pmicef_pkg::R_SD][pmicef_pkg::B_SDB_LIM] = limit_rise[1];
		set_v[pmicef_pkg::R_SU][pmicef_pkg::B_SU_LIM] = limit_rise[2];
		set_v[pmicef_pkg::R_SD][pmicef_pkg::B_SDA_SHORT] = short_evt[0];
		set_v[pmicef_pkg::R_SD][pmicef_pkg::B_SDB_SHORT] = short_evt[1];
		set_v[pmicef_pkg::R_SU][pmicef_pkg::B_SU_SHORT] = short_evt[2];
		set_v[pmicef_pkg::R_SD][pmicef_pkg::B_SDA_PG] = pgood_chg[0];
		set_v[pmicef_pkg::R_SD][pmicef_pkg::B_SDB_PG] = pgood_chg[1];
		set_v[pmicef_pkg::R_SU][pmicef_pkg::B_SU_PG] = pgood_chg[2];
		set_v[pmicef_pkg::R_MON][pmicef_pkg::B_MON_ANALOG] = mon_chg[0];
		set_v[pmicef_pkg::R_MON][pmicef_pkg::B_MON_FIRST] = mon_chg[1];
		set_v[pmicef_pkg::R_MON][pmicef_pkg::B_MON_SECOND] = mon_chg[2];
	end

	always_comb begin
		for (int k = 0; k < 4; k++) begin
			next_flags[k] = flags[k];
			if (wr_sel[k]) begin
				// ones clear sticky bits, reserved bits just store
				next_flags[k] = (flags[k] & ~(pwdata[7:0] & ~pmicef_pkg::FLAG_RW[k])
					& ~pmicef_pkg::FLAG_RW[k]) | (pwdata[7:0] & pmicef_pkg::FLAG_RW[k]);
			end
			if (restart_evt) begin
				next_flags[k] = pmicef_pkg::FLAG_RESET;
			end
			// set applied last so a same-cycle event survives
			next_flags[k] = next_flags[k] | (set_v[k] & ~pmicef_pkg::FLAG_RW[k]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int k = 0; k < 4; k++) begin
				flags[k] <= pmicef_pkg::FLAG_RESET;
			end
		end else begin
			flags <= next_flags;
		end
	end

	// control registers, back to defaults on a reset event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_reg <= pmicef_pkg::ENABLE_RESET;
			mask_reg <= pmicef_pkg::MASK_RESET;
		end else if (restart_evt) begin
			enable_reg <= pmicef_pkg::ENABLE_RESET;
			mask_reg <= pmicef_pkg::MASK_RESET;
		end else if (wr_en && hit) begin
			if (idx == pmicef_pkg::IDX_ENABLE) begin
				enable_reg <= pwdata[2:0];
			end
			if (idx == pmicef_pkg::IDX_MASK) begin
				mask_reg <= pwdata;
			end
		end
	end

	// request bit lives one cycle, then clears itself
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_req <= 1'b0;
		end else if (soft_req) begin
			soft_req <= 1'b0;
		end else if (wr_en && hit && idx == pmicef_pkg::IDX_CONTROL) begin
			soft_req <= pwdata[pmicef_pkg::B_SOFT_RESET];
		end
	end

	// start-up sequence: converters off, reload, run
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= pmicef_pkg::ST_OFF;
			off_cnt <= 5'h0;
		end else if (restart_evt) begin
			state <= pmicef_pkg::ST_OFF;
			off_cnt <= 5'h0;
		end else begin
			case (state)
				pmicef_pkg::ST_OFF: begin
					if (off_cnt == pmicef_pkg::OFF_CYCLES - 5'h1) begin
						state <= pmicef_pkg::ST_START;
					end else begin
						off_cnt <= off_cnt + 5'h1;
					end
				end
				pmicef_pkg::ST_START: begin
					state <= pmicef_pkg::ST_RUN;
				end
				pmicef_pkg::ST_RUN: begin
					state <= pmicef_pkg::ST_RUN;
				end
				default: begin
					state <= pmicef_pkg::ST_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_enable <= 3'h0;
			otp_reload <= 1'b0;
		end else begin
			// drop at once on the event, not a cycle later
			conv_enable <= (restart_evt || state != pmicef_pkg::ST_RUN) ? 3'h0 : enable_reg;
			otp_reload <= !restart_evt && state == pmicef_pkg::ST_START;
		end
	end

	// summary bits follow the flag registers, no state to clear
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			summary[k] = (flags[k] & ~pmicef_pkg::FLAG_RW[k]) != 8'h00;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			// a set mask bit hides its flag from the interrupt line
			irq <= ((flags & ~pmicef_pkg::FLAG_RW) & ~mask_reg) != 32'h0;
		end
	end

	always_comb begin
		rd_data = 32'h0;
		case (idx)
			pmicef_pkg::IDX_RESET_FLAGS: rd_data[7:0] = flags[pmicef_pkg::R_RST];
			pmicef_pkg::IDX_STEPDOWN_FLAGS: rd_data[7:0] = flags[pmicef_pkg::R_SD];
			pmicef_pkg::IDX_STEPUP_FLAGS: rd_data[7:0] = flags[pmicef_pkg::R_SU];
			pmicef_pkg::IDX_MONITOR_FLAGS: rd_data[7:0] = flags[pmicef_pkg::R_MON];
			pmicef_pkg::IDX_TOP_LIVE: rd_data[3:0] = pins_s.live;
			pmicef_pkg::IDX_CONTROL: rd_data[0] = soft_req;
			pmicef_pkg::IDX_ENABLE: rd_data[2:0] = enable_reg;
			pmicef_pkg::IDX_MASK: rd_data = mask_reg;
			pmicef_pkg::IDX_SUMMARY: rd_data[4:0] = {irq, summary};
			default: rd_data = 32'h0;
		endcase
		if (!hit) begin
			rd_data = 32'h0;
		end
	end

	// captured in setup, stable through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable) begin
			prdata <= rd_data;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence restart_s;
		restart_evt;
	endsequence
	sequence conv_off_s;
		(conv_enable == 3'h0) [*8];
	endsequence

	reset_zero_a: assert property ($rose(presetn) |-> flags == '0)
		else $error("flags not zero after reset");
	reset_flag_a: assert property (uv_rise |=> flags[0][0])
		else $error("reset event flag not set");
	restart_off_a: assert property (restart_s |=> conv_off_s)
		else $error("converters not held off after reset event");
	soft_reload_a: assert property ($rose(soft_req) |=> !soft_req ##[1:20] otp_reload)
		else $error("soft reset did not self-clear and reload");
	clear_one_a: assert property ((wr_sel[1] && pwdata[1] && !set_v[1][1]
		&& !restart_evt) |=> !flags[1][1])
		else $error("written one did not clear flag");
	zero_keep_a: assert property ((wr_sel[1] && pwdata[7:0] == 8'h00 && !restart_evt)
		|=> ($past(flags[1]) & ~flags[1]) == 8'h00)
		else $error("written zero changed a flag");
	set_wins_a: assert property ((wr_sel[1] && pwdata[0] && set_v[1][0])
		|=> flags[1][0])
		else $error("event lost against clear");
	limit_flag_a: assert property ((limit_rise[2] && !restart_evt) |=> flags[2][0])
		else $error("step-up limit flag not latched");
	pgood_flag_a: assert property (pgood_chg[1] |=> flags[1][6])
		else $error("step-down b power-good flag not latched");
	monitor_flag_a: assert property (mon_chg[2] |=> flags[3][4])
		else $error("second monitor flag not latched");
	live_read_a: assert property ((psel && !penable && hit
		&& idx == pmicef_pkg::IDX_TOP_LIVE) |=> prdata[3:0] == $past(pins_s.live))
		else $error("live status read mismatch");
	summary_read_a: assert property ((psel && !penable && hit
		&& idx == pmicef_pkg::IDX_SUMMARY)
		|=> prdata[1] == (($past(flags[1]) & ~pmicef_pkg::FLAG_RW[1]) != 8'h00))
		else $error("step-down summary wrong");
	irq_level_a: assert property (((flags[1][0] && !mask_reg[8]) ##1 flags[1][0]) |-> irq)
		else $error("unmasked flag did not raise interrupt");

	sequence boot_pulse_s;
		otp_reload ##1 !otp_reload;
	endsequence

	// each source lands on its own bit, even against a reset event
	short_flag_a: assert property (short_evt[0] |=> flags[1][1])
		else $error("step-down a short flag not latched");
	stepup_short_a: assert property (short_evt[2] |=> flags[2][1])
		else $error("step-up short flag not latched");
	sd_limit_a: assert property (limit_rise[0] |=> flags[1][0])
		else $error("step-down a limit flag not latched");
	su_pgood_a: assert property (pgood_chg[2] |=> flags[2][2])
		else $error("step-up power-good flag not latched");
	soft_flag_a: assert property (soft_req |=> flags[0][0])
		else $error("soft request did not set reset flag");
	restart_regs_a: assert property (restart_evt |=>
		(enable_reg == pmicef_pkg::ENABLE_RESET && mask_reg == pmicef_pkg::MASK_RESET))
		else $error("control registers not back to defaults");
	reserved_clear_a: assert property (restart_evt |=> (flags & pmicef_pkg::FLAG_RW) == 32'h0)
		else $error("reserved storage kept after reset event");
	off_hold_a: assert property (restart_s |=> conv_off_s ##1 conv_off_s)
		else $error("converters not off for the whole off period");
	reload_pulse_a: assert property ($rose(otp_reload) |-> boot_pulse_s)
		else $error("reload pulse longer than one cycle");
	irq_drop_a: assert property (((flags & ~pmicef_pkg::FLAG_RW & ~mask_reg) == 32'h0) |=> !irq)
		else $error("interrupt high with no unmasked flag");
	unmapped_read_a: assert property ((psel && !penable && !hit) |=> prdata == 32'h0)
		else $error("unmapped read returned data");
endmodule
`default_nettype wire

/* logic/pmicef_start_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module pmicef_start_timer #(
	parameter int LIMIT = pmicef_pkg::STARTUP_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic en,
	input wire logic above,
	output logic running,
	output logic short_evt
);
	logic [15:0] count;
	logic waiting;
	logic at_limit;

	assign at_limit = (count == 16'(LIMIT - 1));
	// missed threshold in time, or fell below it once up
	assign short_evt = en && ((waiting && !above && at_limit) || (running && !above));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 16'h0;
			waiting <= 1'b1;
			running <= 1'b0;
		end else if (!en) begin
			count <= 16'h0;
			waiting <= 1'b1;
			running <= 1'b0;
		end else if (waiting) begin
			if (above) begin
				waiting <= 1'b0;
				running <= 1'b1;
			end else if (at_limit) begin
				waiting <= 1'b0;
			end else begin
				count <= count + 16'h1;
			end
		end else if (running && !above) begin
			running <= 1'b0;
		end
	end

	count_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
		count <= 16'(LIMIT - 1))
		else $error("start-up counter ran past its limit");
	run_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
		(en && running && !above) |-> short_evt ##1 !running)
		else $error("running fault did not raise short event");
endmodule
`default_nettype wire

/* tb/tb_pmic_event_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_pmic_event_flags;
	localparam logic [11:0] A_RST = {2'h0, pmicef_pkg::IDX_RESET_FLAGS, 2'h0};
	localparam logic [11:0] A_SD = {2'h0, pmicef_pkg::IDX_STEPDOWN_FLAGS, 2'h0};
	localparam logic [11:0] A_SU = {2'h0, pmicef_pkg::IDX_STEPUP_FLAGS, 2'h0};
	localparam logic [11:0] A_MON = {2'h0, pmicef_pkg::IDX_MONITOR_FLAGS, 2'h0};
	localparam logic [11:0] A_LIVE = {2'h0, pmicef_pkg::IDX_TOP_LIVE, 2'h0};
	localparam logic [11:0] A_CTL = {2'h0, pmicef_pkg::IDX_CONTROL, 2'h0};
	localparam logic [11:0] A_EN = {2'h0, pmicef_pkg::IDX_ENABLE, 2'h0};
	localparam logic [11:0] A_MASK = {2'h0, pmicef_pkg::IDX_MASK, 2'h0};
	localparam logic [11:0] A_SUM = {2'h0, pmicef_pkg::IDX_SUMMARY, 2'h0};
	// index 0x3C decodes to nothing
	localparam logic [11:0] A_BAD = 12'h0F0;
	logic pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, otp_reload, irq, err;
	logic [2:0] conv_enable;
	pmicef_pkg::pmicef_pins_t pins;
	int error_cnt, comparisons;

	// short start-up timeout keeps the run brief
	pmicef_event_flags #(.STARTUP_CYCLES(40)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pins(pins), .conv_enable(conv_enable), .otp_reload(otp_reload), .irq(irq));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic tally_and_finish();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", name, exp, got);
			error_cnt++;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			check("pready", 32'h1, 32'h0);
			tally_and_finish();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(name, exp, rd);
	endtask

	task automatic wait_boot();
		int n;
		n = 0;
		while (otp_reload !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		check("otp_reload", 32'h1, {31'h0, otp_reload});
		if (otp_reload !== 1'b1) begin
			tally_and_finish();
		end
		cyc(3);
		check("conv_enable", 32'h7, {29'h0, conv_enable});
	endtask

	task automatic t_reset();
		for (int i = 0; i < 5; i++) begin
			rchk("reset value", A_RST + 12'(4 * i), 32'h0);
		end
		rchk("mask", A_MASK, 32'h0);
		wr(A_MON, 32'hFF);
		rchk("reserved rw", A_MON, 32'hEA);
		apb(1'b0, A_BAD, 32'h0);
		check("unmapped data", 32'h0, rd);
		check("unmapped err", 32'h1, {31'h0, err});
	endtask

	task automatic t_soft();
		wr(A_MASK, 32'hFF);
		wr(A_CTL, 32'h1);
		cyc(3);
		check("conv off", 32'h0, {29'h0, conv_enable});
		wait_boot();
		rchk("reset flag", A_RST, 32'h1);
		rchk("mask default", A_MASK, 32'h0);
		rchk("reserved default", A_MON, 32'h0);
		rchk("request cleared", A_CTL, 32'h0);
		wr(A_RST, 32'h0);
		rchk("write zero", A_RST, 32'h1);
		wr(A_RST, 32'h1);
		rchk("write one", A_RST, 32'h0);
	endtask

	task automatic t_uv();
		pins.analog_supply_uv <= 1'b1;
		cyc(5);
		pins.analog_supply_uv <= 1'b0;
		wait_boot();
		rchk("uv flag", A_RST, 32'h1);
		wr(A_RST, 32'h1);
	endtask

	task automatic t_limit();
		pins.conv_limit <= 3'h7;
		cyc(6);
		pins.conv_limit <= 3'h0;
		rchk("sd limit", A_SD, 32'h11);
		rchk("su limit", A_SU, 32'h01);
		rchk("summary", A_SUM, 32'h16);
		check("irq on", 32'h1, {31'h0, irq});
		wr(A_MASK, 32'hFFFFFFFF);
		cyc(3);
		check("irq masked", 32'h0, {31'h0, irq});
		wr(A_MASK, 32'h0);
		wr(A_SD, 32'h0);
		rchk("sd kept", A_SD, 32'h11);
		wr(A_SD, 32'h01);
		rchk("sd one", A_SD, 32'h10);
		wr(A_SD, 32'h10);
		wr(A_SU, 32'h01);
		rchk("summary clear", A_SUM, 32'h0);
		check("irq off", 32'h0, {31'h0, irq});
	endtask

	// limit edge lands three edges after the pin, the same edge as the access
	task automatic t_race();
		pins.conv_limit <= 3'h1;
		wr(A_SD, 32'h01);
		rchk("race kept", A_SD, 32'h01);
		pins.conv_limit <= 3'h0;
		wr(A_SD, 32'h01);
		rchk("race cleared", A_SD, 32'h0);
	endtask

	// both directions of the raw level count as an event
	task automatic t_pgood();
		logic [2:0] v;
		for (int k = 0; k < 2; k++) begin
			v = (k == 0) ? 3'h7 : 3'h0;
			pins.conv_pgood <= v;
			pins.monitor_pgood <= v;
			cyc(6);
			rchk("sd pgood", A_SD, 32'h44);
			rchk("su pgood", A_SU, 32'h04);
			rchk("mon pgood", A_MON, 32'h15);
			wr(A_SD, 32'h44);
			wr(A_SU, 32'h04);
			wr(A_MON, 32'h15);
		end
	endtask

	task automatic t_live();
		for (int i = 0; i < 4; i++) begin
			pins.live <= 4'(1 << i);
			cyc(5);
			rchk("live", A_LIVE, 32'(1 << i));
		end
		wr(A_LIVE, 32'hFF);
		rchk("live ro", A_LIVE, 32'h08);
		pins.live <= 4'h0;
	endtask

	task automatic t_short();
		pins.stepdown_above <= 2'b00;
		pins.stepup_above <= 1'b0;
		cyc(6);
		pins.stepdown_above <= 2'b11;
		pins.stepup_above <= 1'b1;
		rchk("sd short", A_SD, 32'h22);
		rchk("su short", A_SU, 32'h02);
		wr(A_SD, 32'h22);
		wr(A_SU, 32'h02);
	endtask

	task automatic t_timeout();
		wr(A_EN, 32'h0);
		cyc(3);
		pins.stepdown_above <= 2'b00;
		pins.stepup_above <= 1'b0;
		cyc(5);
		wr(A_EN, 32'h7);
		cyc(25);
		rchk("sd early", A_SD, 32'h0);
		cyc(25);
		rchk("sd late", A_SD, 32'h22);
		rchk("su late", A_SU, 32'h02);
		pins.stepdown_above <= 2'b11;
		pins.stepup_above <= 1'b1;
		wr(A_SD, 32'h22);
		wr(A_SU, 32'h02);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pins = '0;
		pins.stepdown_above = 2'b11;
		pins.stepup_above = 1'b1;
		error_cnt = 0;
		comparisons = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		wait_boot();
		t_reset();
		t_soft();
		t_uv();
		t_limit();
		t_race();
		t_pgood();
		t_live();
		t_short();
		t_timeout();
		tally_and_finish();
	end
endmodule
`default_nettype wire
